// >>> hw/fmbl_pkg.sv
// address map, flash geometry and command codes for the flash map and boot lock block
// assumes a 14-bit word address on both core memory buses
`default_nettype none
package fmbl_pkg;
  localparam int AW = 14;
  localparam int FL_WORDS = 4096;
  localparam int FL_AW = 12;
  localparam int FL_DW = 24;
  localparam int SFR_COUNT = 4;
  // program memory map
  localparam logic [13:0] PM_USR_HI = 14'h01ff;
  localparam logic [13:0] PM_ROM_LO = 14'h0800;
  localparam logic [13:0] PM_ROM_HI = 14'h17ff;
  localparam logic [13:0] PM_FL_LO = 14'h2000;
  localparam logic [13:0] PM_FL_HI = 14'h2fff;
  // data memory map
  localparam logic [13:0] DM_PER_LO = 14'h2000;
  localparam logic [13:0] DM_PER_HI = 14'h20ff;
  localparam logic [13:0] DM_RAM_LO = 14'h3800;
  localparam logic [13:0] DM_RAM_HI = 14'h39ff;
  localparam logic [13:0] DM_REG2_LO = 14'h3c00;
  // flash interface registers inside the peripheral area
  localparam logic [13:0] DM_FCTRL = 14'h2080;
  localparam logic [13:0] DM_FADDR = 14'h2081;
  localparam logic [13:0] DM_FDLO = 14'h2082;
  localparam logic [13:0] DM_FDHI = 14'h2083;
  // boot addresses
  localparam logic [13:0] RESET_VECTOR = 14'h0800;
  localparam logic [13:0] APP_ENTRY = 14'h2200;
  // sector bounds as flash word offsets: 256, 256 and 3584 words
  localparam logic [11:0] S0_FIRST = 12'h000;
  localparam logic [11:0] S0_LAST = 12'h0ff;
  localparam logic [11:0] S1_FIRST = 12'h100;
  localparam logic [11:0] S1_LAST = 12'h1ff;
  localparam logic [11:0] S2_FIRST = 12'h200;
  localparam logic [11:0] S2_LAST = 12'hfff;
  localparam logic [23:0] ERASED_WORD = 24'h000000;
  localparam logic [7:0] SFR_ERASED = 8'h00;
  // control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 4;
  localparam int CTRL_ERR_BIT = 13;
  localparam int CTRL_LOCK_BIT = 14;
  localparam int CTRL_BUSY_BIT = 15;
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_PROG = 4'h1,
    OP_ERASE_SECT = 4'h2,
    OP_ERASE_ALL = 4'h3,
    OP_SFR_READ = 4'h4,
    OP_SFR_PROG = 4'h5,
    OP_SFR_ERASE = 4'h6,
    OP_LOCK_SET = 4'h7,
    OP_UNLOCK_FULL = 4'h8,
    OP_UNLOCK_KEEP = 4'h9
  } fmbl_op_t;
endpackage
`default_nettype wire

// >>> hw/fmbl_nv.sv
// nonvolatile store: flash array, four user bytes, boot lock and erase sequencer
// assumes one operation at a time, started only while busy is low
`default_nettype none
module fmbl_nv
  import fmbl_pkg::*;
#(
  parameter int WORDS = FL_WORDS
)(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // operation port
  input wire logic op_start,
  input wire logic [3:0] op_code,
  input wire logic [11:0] op_addr,
  input wire logic [23:0] op_wdata,
  output logic busy,
  output logic done,
  output logic [23:0] op_rdata,
  output logic lock,
  // program memory read port
  input wire logic [11:0] rd_addr,
  output logic [23:0] rd_data
);
  typedef enum {NV_IDLE, NV_ERASE} fmbl_nv_st_t;
  fmbl_nv_st_t st;
  // array, user bytes and lock carry no reset: they must survive it
  logic [23:0] mem [WORDS];
  logic [7:0] nonvolatile_user_byte [SFR_COUNT];
  logic [11:0] ptr;
  logic [11:0] last;
  logic unlock_after;
  wire go = op_start && (st == NV_IDLE);
  wire sect_erase = go && (op_code == OP_ERASE_SECT);
  wire full_erase = go && ((op_code == OP_ERASE_ALL) || (op_code == OP_UNLOCK_FULL));
  wire [11:0] sect_first = (op_addr >= S2_FIRST) ? S2_FIRST : (op_addr >= S1_FIRST) ? S1_FIRST : S0_FIRST;
  wire [11:0] sect_last = (op_addr >= S2_FIRST) ? S2_LAST : (op_addr >= S1_FIRST) ? S1_LAST : S0_LAST;
  wire erasing = (st == NV_ERASE);
  wire erase_end = erasing && (ptr == last);
  wire mem_we = (go && (op_code == OP_PROG)) || erasing;
  wire [11:0] mem_wa = erasing ? ptr : op_addr;
  wire [23:0] mem_wd = erasing ? ERASED_WORD : op_wdata;
  wire sfr_prog = go && (op_code == OP_SFR_PROG);
  wire sfr_erase = go && (op_code == OP_SFR_ERASE);
  wire lock_clr = (go && (op_code == OP_UNLOCK_KEEP)) || (erase_end && unlock_after);
  assign busy = erasing;

  always_ff @(posedge mclk)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rd_data <= '0;
    else
      rd_data <= mem[rd_addr];
  end

  for (genvar i = 0; i < SFR_COUNT; i++)
  begin : g_sfr
    always_ff @(posedge mclk)
    begin
      if (sfr_erase)
        nonvolatile_user_byte[i] <= SFR_ERASED;
      else if (sfr_prog && (op_addr[1:0] == 2'(i)))
        nonvolatile_user_byte[i] <= op_wdata[7:0];
    end
  end

  // the full unlock clears the lock only on the last erased word
  always_ff @(posedge mclk)
  begin
    if (go && (op_code == OP_LOCK_SET))
      lock <= 1'b1;
    else if (lock_clr)
      lock <= 1'b0;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= NV_IDLE;
      ptr <= '0;
      last <= '0;
      unlock_after <= 1'b0;
      done <= 1'b0;
      op_rdata <= '0;
    end
    else
    begin
      done <= (go && !sect_erase && !full_erase) || erase_end;
      if (go && (op_code == OP_READ))
        op_rdata <= mem[op_addr];
      else if (go && (op_code == OP_SFR_READ))
        op_rdata <= {16'h0000, nonvolatile_user_byte[op_addr[1:0]]};
      case (st)
        NV_IDLE:
        begin
          if (sect_erase || full_erase)
          begin
            st <= NV_ERASE;
            ptr <= sect_erase ? sect_first : S0_FIRST;
            last <= sect_erase ? sect_last : S2_LAST;
            unlock_after <= (op_code == OP_UNLOCK_FULL);
          end
        end
        NV_ERASE:
        begin
          ptr <= ptr + 12'h001;
          if (erase_end)
          begin
            st <= NV_IDLE;
            unlock_after <= 1'b0;
          end
        end
        default: st <= NV_IDLE;
      endcase
    end
  end

  a_sect_bounds: assert property (@(posedge mclk) disable iff (!nrst)
    sect_erase && (op_addr >= S1_FIRST) && (op_addr <= S1_LAST) |=> erasing && ptr == S1_FIRST && last == S1_LAST)
    else $error("sector one erase bounds wrong");
  a_sfr_erase: assert property (@(posedge mclk) disable iff (!nrst)
    sfr_erase |=> nonvolatile_user_byte[0] == SFR_ERASED && nonvolatile_user_byte[1] == SFR_ERASED && nonvolatile_user_byte[2] == SFR_ERASED && nonvolatile_user_byte[3] == SFR_ERASED)
    else $error("user bytes not zero after erase");
  a_unlock_order: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(lock) |-> $past(erase_end && unlock_after) || $past(go && op_code == OP_UNLOCK_KEEP))
    else $error("lock cleared without unlock");
  a_unlock_keep: assert property (@(posedge mclk) disable iff (!nrst)
    go && op_code == OP_UNLOCK_KEEP |=> !lock && !erasing && done)
    else $error("keep unlock misbehaved");
endmodule
`default_nettype wire

// >>> hw/fmbl_top.sv
// program and data memory decode, flash interface registers, debug path and boot lock
// assumes core buses and debug requests are synchronous to mclk; memories outside
`default_nettype none
module fmbl_top
  import fmbl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // program memory bus
  input wire logic [13:0] pm_addr,
  input wire logic pm_rd,
  input wire logic pm_fetch,
  input wire logic pm_wr,
  output logic pm_ram_sel,
  output logic pm_rom_sel,
  output logic pm_flash_sel,
  output logic pm_rvalid,
  output logic [23:0] pm_rdata,
  // data memory bus
  input wire logic [13:0] dm_addr,
  input wire logic dm_rd,
  input wire logic dm_wr,
  input wire logic [15:0] dm_wdata,
  output logic dm_ram_sel,
  output logic dm_per_sel,
  output logic dm_reg2_sel,
  output logic dm_rvalid,
  output logic [15:0] dm_rdata,
  // external programming and debug path
  input wire logic dbg_start,
  input wire logic [3:0] dbg_op,
  input wire logic [11:0] dbg_addr,
  input wire logic [23:0] dbg_wdata,
  output logic dbg_done,
  output logic dbg_refused,
  output logic [23:0] dbg_rdata,
  // boot status
  output logic [13:0] boot_vector,
  output logic boot_from_flash,
  output logic boot_ext_load
);
  logic [3:0] flash_control_reg;
  logic [11:0] flash_address_reg;
  logic [15:0] flash_data_low_reg;
  logic [7:0] flash_data_high_reg;
  logic err;
  logic user_ran;
  logic owner_dbg;
  logic boot_taken;
  logic nv_busy;
  logic nv_done;
  logic nv_lock;
  logic [23:0] nv_rdata;

  // decode
  wire pm_acc = pm_rd || pm_wr;
  wire dm_acc = dm_rd || dm_wr;
  wire pm_in_ram = (pm_addr <= PM_USR_HI);
  wire pm_in_rom = (pm_addr >= PM_ROM_LO) && (pm_addr <= PM_ROM_HI);
  wire pm_in_fl = (pm_addr >= PM_FL_LO) && (pm_addr <= PM_FL_HI);
  wire [11:0] pm_fl_word = 12'(pm_addr - PM_FL_LO);
  wire dm_in_per = (dm_addr >= DM_PER_LO) && (dm_addr <= DM_PER_HI);
  wire dm_in_ram = (dm_addr >= DM_RAM_LO) && (dm_addr <= DM_RAM_HI);
  wire dm_in_reg2 = (dm_addr >= DM_REG2_LO);
  wire hit_ctrl = dm_addr == DM_FCTRL;
  wire hit_addr = dm_addr == DM_FADDR;
  wire hit_dlo = dm_addr == DM_FDLO;
  wire hit_dhi = dm_addr == DM_FDHI;
  wire freg_hit = hit_ctrl || hit_addr || hit_dlo || hit_dhi;

  // core command path; unlock needs user code to have run from flash
  wire [3:0] core_op = dm_wdata[CTRL_OP_LSB +: 4];
  wire core_go = dm_wr && hit_ctrl && dm_wdata[CTRL_GO_BIT];
  wire core_unlock = (core_op == OP_UNLOCK_FULL) || (core_op == OP_UNLOCK_KEEP);
  wire core_ok = core_go && !nv_busy && (!core_unlock || user_ran);
  wire dbg_unlock = (dbg_op == OP_UNLOCK_FULL) || (dbg_op == OP_UNLOCK_KEEP);
  wire dbg_ok = dbg_start && !nv_lock && !nv_busy && !core_go && !dbg_unlock;
  wire nv_start = core_ok || dbg_ok;
  wire [3:0] nv_op = core_ok ? core_op : dbg_op;
  wire [11:0] nv_addr = core_ok ? flash_address_reg : dbg_addr;
  wire [23:0] nv_wdata = core_ok ? {flash_data_high_reg, flash_data_low_reg} : dbg_wdata;
  wire core_rd_done = nv_done && !owner_dbg && ((flash_control_reg == OP_READ) || (flash_control_reg == OP_SFR_READ));
  wire [15:0] ctrl_view = {nv_busy, nv_lock, err, 9'h000, flash_control_reg};
  wire [15:0] freg_view = hit_ctrl ? ctrl_view :
                          hit_addr ? {4'h0, flash_address_reg} :
                          hit_dlo ? flash_data_low_reg : {8'h00, flash_data_high_reg};

  fmbl_nv #(
    .WORDS(FL_WORDS)
  ) u_nv (
    .mclk(mclk),
    .nrst(nrst),
    .op_start(nv_start),
    .op_code(nv_op),
    .op_addr(nv_addr),
    .op_wdata(nv_wdata),
    .busy(nv_busy),
    .done(nv_done),
    .op_rdata(nv_rdata),
    .lock(nv_lock),
    .rd_addr(pm_fl_word),
    .rd_data(pm_rdata)
  );

  // selects follow the access by one cycle; reserved ranges select nothing
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pm_ram_sel <= 1'b0;
      pm_rom_sel <= 1'b0;
      pm_flash_sel <= 1'b0;
      pm_rvalid <= 1'b0;
      dm_ram_sel <= 1'b0;
      dm_per_sel <= 1'b0;
      dm_reg2_sel <= 1'b0;
      dm_rvalid <= 1'b0;
      dm_rdata <= '0;
    end
    else
    begin
      pm_ram_sel <= pm_acc && pm_in_ram;
      pm_rom_sel <= pm_acc && pm_in_rom;
      pm_flash_sel <= pm_acc && pm_in_fl;
      pm_rvalid <= pm_rd && pm_in_fl;
      dm_ram_sel <= dm_acc && dm_in_ram;
      dm_per_sel <= dm_acc && dm_in_per;
      dm_reg2_sel <= dm_acc && dm_in_reg2;
      dm_rvalid <= dm_rd && freg_hit;
      dm_rdata <= (dm_rd && freg_hit) ? freg_view : 16'h0000;
    end
  end

  // flash interface registers; writes accepted though only ROM routines should use them
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      flash_control_reg <= '0;
      flash_address_reg <= '0;
      flash_data_low_reg <= '0;
      flash_data_high_reg <= '0;
      err <= 1'b0;
    end
    else
    begin
      if (dm_wr && hit_ctrl)
        flash_control_reg <= core_op;
      if (dm_wr && hit_addr)
        flash_address_reg <= dm_wdata[11:0];
      if (core_rd_done)
        {flash_data_high_reg, flash_data_low_reg} <= nv_rdata;
      else
      begin
        if (dm_wr && hit_dlo)
          flash_data_low_reg <= dm_wdata;
        if (dm_wr && hit_dhi)
          flash_data_high_reg <= dm_wdata[7:0];
      end
      if (core_go)
        err <= !core_ok;
    end
  end

  // debug answers and ownership of the running operation
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      owner_dbg <= 1'b0;
      dbg_done <= 1'b0;
      dbg_refused <= 1'b0;
      dbg_rdata <= '0;
      user_ran <= 1'b0;
    end
    else
    begin
      if (nv_start)
        owner_dbg <= dbg_ok;
      dbg_done <= nv_done && owner_dbg;
      dbg_refused <= dbg_start && !dbg_ok;
      if (nv_done && owner_dbg)
        dbg_rdata <= nv_rdata;
      if (pm_rd && pm_fetch && pm_in_fl)
        user_ran <= 1'b1;
    end
  end

  // lock is sampled once after reset release; it is not reset itself
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      boot_vector <= RESET_VECTOR;
      boot_taken <= 1'b0;
      boot_from_flash <= 1'b0;
      boot_ext_load <= 1'b0;
    end
    else if (!boot_taken)
    begin
      boot_taken <= 1'b1;
      boot_from_flash <= nv_lock;
      boot_ext_load <= !nv_lock;
    end
  end

  a_rom_decode: assert property (@(posedge mclk) disable iff (!nrst)
    pm_acc && pm_addr >= PM_ROM_LO && pm_addr <= PM_ROM_HI |=> pm_rom_sel && !pm_ram_sel && !pm_flash_sel)
    else $error("rom range not selected");
  a_flash_decode: assert property (@(posedge mclk) disable iff (!nrst)
    pm_rd && pm_addr >= APP_ENTRY && pm_addr <= PM_FL_HI |=> pm_flash_sel && pm_rvalid)
    else $error("flash range not selected");
  a_per_decode: assert property (@(posedge mclk) disable iff (!nrst)
    dm_acc && dm_addr >= DM_PER_LO && dm_addr <= DM_PER_HI |=> dm_per_sel && !dm_ram_sel)
    else $error("peripheral range not selected");
  a_reserved_dm: assert property (@(posedge mclk) disable iff (!nrst)
    dm_acc && dm_addr > DM_PER_HI && dm_addr < DM_RAM_LO |=> !dm_per_sel && !dm_ram_sel && !dm_reg2_sel)
    else $error("reserved data range selected");
  a_freg_read: assert property (@(posedge mclk) disable iff (!nrst)
    dm_rd && hit_addr && !dm_wr |=> dm_rvalid && dm_rdata == {4'h0, $past(flash_address_reg)})
    else $error("address register read wrong");
  a_dbg_locked: assert property (@(posedge mclk) disable iff (!nrst)
    dbg_start && nv_lock |-> !(nv_start && !core_ok) ##1 dbg_refused)
    else $error("debug access while locked");
  a_unlock_gate: assert property (@(posedge mclk) disable iff (!nrst)
    core_go && core_unlock && !user_ran |-> !nv_start ##1 err)
    else $error("unlock taken outside user code");
  // case equality: an unprogrammed lock must not trip the first boot after power-up
  a_boot_path: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(boot_taken) |-> boot_from_flash === $past(nv_lock) && boot_ext_load === !$past(nv_lock))
    else $error("boot path disagrees with lock");
  a_boot_vector: assert property (@(posedge mclk) disable iff (!nrst)
    !boot_taken |=> boot_vector == RESET_VECTOR && boot_taken)
    else $error("reset vector wrong");
endmodule
`default_nettype wire

// >>> verif/fmbl_core_model.sv
// processor core model: drives the program and data memory buses of the flash map block
// assumes callers enter its tasks a small delay after a rising edge of mclk
`default_nettype none
module fmbl_core_model
(
  // clock
  input wire logic mclk,
  // program memory bus
  output logic [13:0] pm_addr,
  output logic pm_rd,
  output logic pm_fetch,
  output logic pm_wr,
  // data memory bus
  output logic [13:0] dm_addr,
  output logic dm_rd,
  output logic dm_wr,
  output logic [15:0] dm_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    pm_addr = 14'h0000;
    pm_rd = 1'b0;
    pm_fetch = 1'b0;
    pm_wr = 1'b0;
    dm_addr = 14'h0000;
    dm_rd = 1'b0;
    dm_wr = 1'b0;
    dm_wdata = 16'h0000;
  end

  // one program bus cycle; returns just after the edge that took it
  task automatic pm_cycle(input logic [13:0] a, input logic rd, input logic f, input logic wr);
    @(posedge mclk);
    #1;
    pm_addr = a;
    pm_rd = rd;
    pm_fetch = f;
    pm_wr = wr;
    @(posedge mclk);
    #1;
    pm_rd = 1'b0;
    pm_fetch = 1'b0;
    pm_wr = 1'b0;
    // released lines must not keep the last value
    pm_addr = ~a;
  endtask

  // one data bus cycle; writes here come from the wr task and one direct reserved-range write
  task automatic dm_cycle(input logic [13:0] a, input logic rd, input logic wr, input logic [15:0] wd);
    @(posedge mclk);
    #1;
    dm_addr = a;
    dm_rd = rd;
    dm_wr = wr;
    dm_wdata = wd;
    @(posedge mclk);
    #1;
    dm_rd = 1'b0;
    dm_wr = 1'b0;
    dm_addr = ~a;
    dm_wdata = ~wd;
  endtask
endmodule
`default_nettype wire

// >>> verif/fmbl_top_bench.sv
// self-checking bench for the flash map and boot lock block
// assumes the core model drives both buses; nonvolatile state is set up by erase, lock set and keep unlock ops
`default_nettype none
module fmbl_top_bench
  import fmbl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic dm; logic [13:0] a; logic [2:0] sel;} fmbl_row_t;
  logic mclk, nrst, pm_rd, pm_fetch, pm_wr, dm_rd, dm_wr;
  logic [13:0] pm_addr, dm_addr, boot_vector;
  logic [15:0] dm_wdata, dm_rdata, s;
  logic pm_ram_sel, pm_rom_sel, pm_flash_sel, pm_rvalid, dm_ram_sel, dm_per_sel, dm_reg2_sel, dm_rvalid;
  logic [23:0] pm_rdata, dbg_wdata, dbg_rdata;
  logic dbg_start, dbg_done, dbg_refused, boot_from_flash, boot_ext_load, ok, no;
  logic [3:0] dbg_op;
  logic [11:0] dbg_addr;
  int bad_count = 0;
  int n_tests = 0;
  // pm sel = {ram, rom, flash}; dm sel = {ram, per, reg2}
  fmbl_row_t rows [0:26] = '{
    '{1'b0, 14'h0000, 3'h4}, '{1'b0, 14'h002f, 3'h4}, '{1'b0, 14'h0030, 3'h4}, '{1'b0, 14'h01ff, 3'h4},
    '{1'b0, 14'h0200, 3'h0}, '{1'b0, 14'h07ff, 3'h0}, '{1'b0, 14'h0800, 3'h2}, '{1'b0, 14'h17ff, 3'h2},
    '{1'b0, 14'h1800, 3'h0}, '{1'b0, 14'h2000, 3'h1}, '{1'b0, 14'h20ff, 3'h1}, '{1'b0, 14'h2100, 3'h1},
    '{1'b0, 14'h2200, 3'h1}, '{1'b0, 14'h2fff, 3'h1}, '{1'b0, 14'h3000, 3'h0}, '{1'b0, 14'h3fff, 3'h0},
    '{1'b1, 14'h1fff, 3'h0}, '{1'b1, 14'h2000, 3'h2}, '{1'b1, 14'h20ff, 3'h2}, '{1'b1, 14'h2100, 3'h0},
    '{1'b1, 14'h37ff, 3'h0}, '{1'b1, 14'h3800, 3'h4}, '{1'b1, 14'h39ff, 3'h4}, '{1'b1, 14'h3a00, 3'h0},
    '{1'b1, 14'h3bff, 3'h0}, '{1'b1, 14'h3c00, 3'h1}, '{1'b1, 14'h3fff, 3'h1}};
  logic [11:0] wa [0:3] = '{12'h0ff, 12'h100, 12'h200, 12'hfff};
  logic [23:0] wv [0:3] = '{24'h0a0b0c, 24'hc0ffee, 24'h345678, 24'h800001};

  fmbl_core_model fmbl_core_model_i (.mclk(mclk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_fetch(pm_fetch),
    .pm_wr(pm_wr), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata));
  fmbl_top fmbl_top_i (.mclk(mclk), .nrst(nrst), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_fetch(pm_fetch),
    .pm_wr(pm_wr), .pm_ram_sel(pm_ram_sel), .pm_rom_sel(pm_rom_sel), .pm_flash_sel(pm_flash_sel),
    .pm_rvalid(pm_rvalid), .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_wdata(dm_wdata), .dm_ram_sel(dm_ram_sel), .dm_per_sel(dm_per_sel), .dm_reg2_sel(dm_reg2_sel),
    .dm_rvalid(dm_rvalid), .dm_rdata(dm_rdata), .dbg_start(dbg_start), .dbg_op(dbg_op), .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata), .dbg_done(dbg_done), .dbg_refused(dbg_refused), .dbg_rdata(dbg_rdata),
    .boot_vector(boot_vector), .boot_from_flash(boot_from_flash), .boot_ext_load(boot_ext_load));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    fmbl_core_model_i.dm_cycle(a, 1'b0, 1'b1, d);
  endtask

  task automatic rd(input logic [13:0] a, output logic [15:0] d);
    fmbl_core_model_i.dm_cycle(a, 1'b1, 1'b0, 16'h0000);
    chk(dm_rvalid, 24'h1);
    d = dm_rdata;
  endtask

  // launch an op, then poll busy under a bound
  task automatic op(input logic [3:0] c, input int lim);
    int i;
    wr(DM_FCTRL, {11'h000, 1'b1, c});
    for (i = 0; i < lim; i++)
    begin
      rd(DM_FCTRL, s);
      if (s[15] === 1'b0)
        break;
    end
    chk(s[15], 24'h0);
  endtask

  task automatic pmchk(input logic [13:0] a, input logic f, input logic [23:0] w);
    fmbl_core_model_i.pm_cycle(a, 1'b1, f, 1'b0);
    chk(pm_rvalid, 24'h1);
    chk(pm_rdata, w);
  endtask

  task automatic dbg(input logic [3:0] c, input logic [11:0] a, input logic [23:0] w);
    // an edge first, so a following call never lowers and raises start in one step
    @(posedge mclk);
    #1;
    dbg_op = c;
    dbg_addr = a;
    dbg_wdata = w;
    dbg_start = 1'b1;
    ok = 1'b0;
    no = 1'b0;
    repeat (4)
    begin
      @(posedge mclk);
      #1;
      dbg_start = 1'b0;
      ok = ok | dbg_done;
      no = no | dbg_refused;
    end
  endtask

  task automatic rst_boot(input logic lk);
    nrst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk(boot_vector, RESET_VECTOR);
    nrst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({boot_from_flash, boot_ext_load}, {lk, ~lk});
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    results;
  end

  initial
  begin
    nrst = 1'b0;
    dbg_start = 1'b0;
    dbg_op = 4'h0;
    dbg_addr = 12'h000;
    dbg_wdata = 24'h000000;
    @(posedge mclk);
    #1;
    repeat (3) @(posedge mclk);
    #1;
    nrst = 1'b1;
    chk(boot_vector, RESET_VECTOR);
    foreach (rows[i])
    begin
      if (rows[i].dm)
      begin
        fmbl_core_model_i.dm_cycle(rows[i].a, 1'b1, 1'b0, 16'h0000);
        chk({dm_ram_sel, dm_per_sel, dm_reg2_sel}, rows[i].sel);
      end
      else
      begin
        fmbl_core_model_i.pm_cycle(rows[i].a, 1'b1, 1'b0, 1'b0);
        chk({pm_ram_sel, pm_rom_sel, pm_flash_sel}, rows[i].sel);
      end
    end
    // lock state is unknown at power-up, so set it and clear it the legal way
    op(OP_ERASE_ALL, 3000);
    op(OP_LOCK_SET, 20);
    op(OP_SFR_ERASE, 20);
    pmchk(APP_ENTRY, 1'b1, ERASED_WORD);
    op(OP_UNLOCK_KEEP, 20);
    // application placed at the entry word while unlocked, before the lock is set again
    for (int i = 0; i < 4; i++)
    begin
      wr(DM_FADDR, {4'h0, wa[i]});
      wr(DM_FDLO, wv[i][15:0]);
      wr(DM_FDHI, {8'h00, wv[i][23:16]});
      op(OP_PROG, 20);
      pmchk(PM_FL_LO + {2'b00, wa[i]}, 1'b0, wv[i]);
    end
    wr(DM_FADDR, 16'h0200);
    op(OP_READ, 20);
    rd(DM_FDLO, s);
    chk(s, 24'h005678);
    rd(DM_FDHI, s);
    chk(s, 24'h000034);
    wr(DM_FADDR, 16'h0100);
    op(OP_ERASE_SECT, 300);
    pmchk(14'h20ff, 1'b0, wv[0]);
    pmchk(14'h2100, 1'b0, ERASED_WORD);
    pmchk(14'h2fff, 1'b0, wv[3]);
    fmbl_core_model_i.dm_cycle(14'h2100, 1'b0, 1'b1, 16'hffff);
    chk({dm_ram_sel, dm_per_sel, dm_reg2_sel}, 24'h0);
    fmbl_core_model_i.pm_cycle(APP_ENTRY, 1'b0, 1'b0, 1'b1);
    pmchk(APP_ENTRY, 1'b0, wv[2]);
    wr(DM_FADDR, 16'h0002);
    op(OP_SFR_READ, 20);
    rd(DM_FDLO, s);
    chk(s[7:0], SFR_ERASED);
    wr(DM_FADDR, 16'h0001);
    wr(DM_FDLO, 16'h00a5);
    op(OP_SFR_PROG, 20);
    op(OP_SFR_READ, 20);
    rd(DM_FDLO, s);
    chk(s[7:0], 24'ha5);
    dbg(OP_READ, 12'h200, 24'h000000);
    chk({ok, no}, 24'h2);
    chk(dbg_rdata, wv[2]);
    op(OP_LOCK_SET, 20);
    dbg(OP_PROG, 12'h200, 24'h111111);
    chk({ok, no}, 24'h1);
    dbg(OP_READ, 12'h200, 24'h000000);
    chk({ok, no}, 24'h1);
    rst_boot(1'b1);
    op(OP_UNLOCK_FULL, 20);
    chk(s[14:13], 24'h3);
    pmchk(APP_ENTRY, 1'b1, wv[2]);
    op(OP_UNLOCK_KEEP, 20);
    chk(s[14:13], 24'h0);
    pmchk(APP_ENTRY, 1'b0, wv[2]);
    op(OP_LOCK_SET, 20);
    op(OP_UNLOCK_FULL, 5000);
    chk(s[14:13], 24'h0);
    pmchk(APP_ENTRY, 1'b0, ERASED_WORD);
    pmchk(14'h20ff, 1'b0, ERASED_WORD);
    rst_boot(1'b0);
    results;
  end
endmodule
`default_nettype wire
